// ### logic/adc_dual_device.sv
// Operation
// - Host supplies 100 kHz to 55 MHz clock; its four-cycle half period floor caps it at 25 MHz
// - Sampling clock duty cycle near fifty percent
// - Sampling clock never stopped or too slow; host stops it while run is clear
// - Active-low enable per channel floats its bus; the link model shows the inverted word on a released lane instead
// - Conversion continues whatever the output enables
// - Power-down high stops conversion, low resumes
// - Power-down loses pipeline, outputs undefined
// - Host discards data until bypass recharge
// - Format low offset binary, high two's complement
// - Host discards words after format change
// - Reference select low internal, high external
// - Two twelve-bit outputs, valid when enabled, running
// - Data changes shortly after sampling clock rise
// - Host captures output words on falling edge
// - Two's complement is offset binary, top inverted
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module adc_dual_device (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	adc_link_if.device link,
	input wire adc_ctrl_pkg::sample_type i_CHAN_A_SAMPLE,
	input wire adc_ctrl_pkg::sample_type i_CHAN_B_SAMPLE,
	output logic o_SAMPLE_TAKEN,
	output logic o_LOW_POWER,
	output logic o_EXT_REF_SELECTED,
	output logic o_CHAN_A_DRIVEN,
	output logic o_CHAN_B_DRIVEN
);
	import adc_ctrl_pkg::*;

	localparam int LAT = `PIPE_LATENCY;

	logic [5:0] pin_meta_q;
	logic [5:0] pin_sync_q;
	logic sclk_prev_q;
	logic sclk_rise;
	logic oea_n;
	logic oeb_n;
	logic pdown;
	logic fmt;
	logic refext;
	pwr_state_type state_q;
	pwr_state_type state_d;
	sample_type pipe_a_q [LAT];
	sample_type pipe_b_q [LAT];
	logic [LAT-1:0] pipe_ok_q;
	sample_type out_a_q;
	sample_type out_b_q;
	logic out_a_oe_n_q;
	logic out_b_oe_n_q;
	logic taken_q;

	////////////////////////////////////////////////////////////////////////////
	// Pin input synchronisers
	////////////////////////////////////////////////////////////////////////////

	// All control pins come from the host's domain, so each passes two flops
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pin_meta_q <= 6'h00;
			pin_sync_q <= 6'h00;
		end else begin
			pin_meta_q <= {link.sample_clk, link.chan_a_out_enable_n, link.chan_b_out_enable_n,
				link.power_down_in, link.format_select, link.reference_select};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign oea_n = pin_sync_q[4];
	assign oeb_n = pin_sync_q[3];
	assign pdown = pin_sync_q[2];
	assign fmt = pin_sync_q[1];
	assign refext = pin_sync_q[0];

	// Edge detect reads only the second stage, never the first
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= pin_sync_q[5];
		end
	end

	// One sampling operation per sampling clock period, on its rise
	assign sclk_rise = pin_sync_q[5] & ~sclk_prev_q;

	////////////////////////////////////////////////////////////////////////////
	// Power state
	////////////////////////////////////////////////////////////////////////////

	// Power-down is a plain level; leaving it resumes conversion at once
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_RUN: begin
				if (pdown) begin
					state_d = ST_PDOWN;
				end
			end
			ST_PDOWN: begin
				if (!pdown) begin
					state_d = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion pipeline
	////////////////////////////////////////////////////////////////////////////

	// Both channels shift on the same sampling edge; the output enables are
	// not consulted, so hidden channels keep converting
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < LAT; i++) begin
				pipe_a_q[i] <= 12'h800;
				pipe_b_q[i] <= 12'h800;
			end
		end else if (sclk_rise && state_q == ST_RUN) begin
			pipe_a_q[0] <= i_CHAN_A_SAMPLE;
			pipe_b_q[0] <= i_CHAN_B_SAMPLE;
			for (int i = 1; i < LAT; i++) begin
				pipe_a_q[i] <= pipe_a_q[i-1];
				pipe_b_q[i] <= pipe_b_q[i-1];
			end
		end
	end

	// Track which stages hold a real sample; power-down wipes them all
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pipe_ok_q <= '0;
		end else if (state_q == ST_PDOWN) begin
			pipe_ok_q <= '0;
		end else if (sclk_rise) begin
			pipe_ok_q <= {pipe_ok_q[LAT-2:0], 1'b1};
		end
	end

	// Pulse out for the sample model so it can present the next input word
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			taken_q <= 1'b0;
		end else begin
			taken_q <= sclk_rise && state_q == ST_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output stage
	////////////////////////////////////////////////////////////////////////////

	// Words leave the pipeline in the format selected at that moment, so a
	// format change can garble words already in flight for the host's view
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			out_a_q <= 12'h000;
			out_b_q <= 12'h000;
		end else if (state_q == ST_PDOWN) begin
			out_a_q <= 12'h000;
			out_b_q <= 12'h000;
		end else if (sclk_rise) begin
			out_a_q <= to_format(pipe_a_q[LAT-1], fmt);
			out_b_q <= to_format(pipe_b_q[LAT-1], fmt);
		end
	end

	// Lane release follows the synchronised enable pins, one per channel
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			out_a_oe_n_q <= 1'b1;
			out_b_oe_n_q <= 1'b1;
		end else begin
			out_a_oe_n_q <= oea_n;
			out_b_oe_n_q <= oeb_n;
		end
	end

	// Twelve data lanes per channel, twenty-four in all
	assign link.chan_a_data = out_a_q;
	assign link.chan_b_data = out_b_q;
	assign link.chan_a_data_oe_n = out_a_oe_n_q;
	assign link.chan_b_data_oe_n = out_b_oe_n_q;

	////////////////////////////////////////////////////////////////////////////
	// User side status
	////////////////////////////////////////////////////////////////////////////

	// Reference choice is shared by both converters; high means the board
	// must supply the reference voltage
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			o_EXT_REF_SELECTED <= 1'b0;
			o_LOW_POWER <= 1'b0;
			o_CHAN_A_DRIVEN <= 1'b0;
			o_CHAN_B_DRIVEN <= 1'b0;
		end else begin
			o_EXT_REF_SELECTED <= refext;
			o_LOW_POWER <= state_q == ST_PDOWN;
			// Valid words only while enabled and not powered down
			o_CHAN_A_DRIVEN <= !oea_n && state_q == ST_RUN && pipe_ok_q[LAT-1];
			o_CHAN_B_DRIVEN <= !oeb_n && state_q == ST_RUN && pipe_ok_q[LAT-1];
		end
	end

	assign o_SAMPLE_TAKEN = taken_q;

endmodule : adc_dual_device

`default_nettype wire

// ### logic/adc_ctrl_defs.svh
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// Clock rate of I_MCLK and sampling clock limits
`define MCLK_HZ 200000000
`define SCLK_MAX_HZ 55000000
`define SCLK_MIN_HZ 100000
// Half period bounds of the generated sampling clock, in I_MCLK cycles
`define HALF_MIN_RULE ((`MCLK_HZ + 2 * `SCLK_MAX_HZ - 1) / (2 * `SCLK_MAX_HZ))
`define HALF_MAX_RULE (`MCLK_HZ / (2 * `SCLK_MIN_HZ))
// Host needs this many cycles per half period to see the data settle through its synchronisers
`define HALF_MIN_SYNC 4
`define HALF_RESET 10

// Conversion pipeline depth in sampling clock periods
`define PIPE_LATENCY 4
// Sampling periods of data discarded after a format change
`define FMT_DISCARD 8
// Default sampling periods discarded after power-down release, on top of the pipeline refill
`define RECOVER_RESET 16'h0400

// Data word layout
`define SAMPLE_BITS 12
`define SAMPLE_MSB 11

// Host register byte offsets
`define REG_CTRL 12'h000
`define REG_DIV 12'h004
`define REG_DATA 12'h008
`define REG_STATUS 12'h00C
`define REG_RECOVER 12'h010

// Control register field positions
`define CTRL_RUN 0
`define CTRL_PDOWN 1
`define CTRL_FORMAT 2
`define CTRL_REFEXT 3
`define CTRL_OEA_N 4
`define CTRL_OEB_N 5
`define CTRL_RESET 32'h00000030

// Data register field positions
`define DATA_A_LSB 0
`define DATA_B_LSB 12
`define DATA_FRESH 31

`endif

// ### logic/adc_ctrl_pkg.sv
`default_nettype none

package adc_ctrl_pkg;

	typedef logic [11:0] sample_type;

	typedef enum logic {
		ST_RUN,
		ST_PDOWN
	} pwr_state_type;

	// Offset binary to two's complement is a flip of the top bit
	function automatic sample_type to_format(input sample_type offs, input logic twos);
		to_format = {offs[11] ^ twos, offs[10:0]};
	endfunction : to_format

endpackage : adc_ctrl_pkg

`default_nettype wire

// ### logic/adc_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface adc_link_if;
	import adc_ctrl_pkg::*;

	logic sample_clk;
	logic chan_a_out_enable_n;
	logic chan_b_out_enable_n;
	logic power_down_in;
	logic format_select;
	logic reference_select;
	sample_type chan_a_data;
	logic chan_a_data_oe_n;
	sample_type chan_b_data;
	logic chan_b_data_oe_n;
	// Resolved pin levels; a released lane shows the inverse of its word, so a
	// host that reads it anyway gets nonsense rather than a plausible sample
	wire [11:0] chan_a_bus;
	wire [11:0] chan_b_bus;

	assign chan_a_bus = chan_a_data_oe_n ? ~chan_a_data : chan_a_data;
	assign chan_b_bus = chan_b_data_oe_n ? ~chan_b_data : chan_b_data;

	modport device (
		input sample_clk, chan_a_out_enable_n, chan_b_out_enable_n,
		input power_down_in, format_select, reference_select,
		output chan_a_data, chan_a_data_oe_n, chan_b_data, chan_b_data_oe_n
	);

	modport host (
		output sample_clk, chan_a_out_enable_n, chan_b_out_enable_n,
		output power_down_in, format_select, reference_select,
		input chan_a_bus, chan_b_bus
	);

endinterface : adc_link_if

`default_nettype wire

// ### logic/adc_capture_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module adc_capture_host (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	adc_link_if.host link,
	input wire logic i_PSEL,
	input wire logic i_PENABLE,
	input wire logic i_PWRITE,
	input wire logic [11:0] i_PADDR,
	input wire logic [31:0] i_PWDATA,
	output logic [31:0] o_PRDATA,
	output logic o_PREADY,
	output logic o_PSLVERR
);
	import adc_ctrl_pkg::*;

	logic [31:0] ctrl_q;
	logic [9:0] half_q;
	logic [15:0] recover_q;
	logic [9:0] div_cnt_q;
	logic sclk_q;
	logic fall_pulse;
	logic [23:0] bus_meta_q;
	logic [23:0] bus_sync_q;
	logic [11:0] word_a_q;
	logic [11:0] word_b_q;
	logic fresh_q;
	logic [15:0] discard_q;
	logic [15:0] count_q;
	logic wr_en;
	logic rd_en;
	logic pd_fall;
	logic fmt_chg;
	logic run_rise;

	// Keep the divider inside the legal sampling range and the sync budget
	function automatic logic [9:0] clamp_half(input logic [31:0] v);
		logic [31:0] lo;
		lo = (`HALF_MIN_RULE > `HALF_MIN_SYNC) ? `HALF_MIN_RULE : `HALF_MIN_SYNC;
		if (v < lo) begin
			clamp_half = lo[9:0];
		end else if (v > `HALF_MAX_RULE) begin
			clamp_half = 10'(`HALF_MAX_RULE);
		end else begin
			clamp_half = v[9:0];
		end
	endfunction : clamp_half

	////////////////////////////////////////////////////////////////////////////
	// APB slave
	////////////////////////////////////////////////////////////////////////////

	assign wr_en = i_PSEL & i_PENABLE & i_PWRITE;
	assign rd_en = i_PSEL & i_PENABLE & ~i_PWRITE;
	assign o_PREADY = 1'b1;
	assign o_PSLVERR = i_PSEL & i_PENABLE & ~(i_PADDR == `REG_CTRL || i_PADDR == `REG_DIV ||
		i_PADDR == `REG_DATA || i_PADDR == `REG_STATUS || i_PADDR == `REG_RECOVER);

	// Control registers written by software
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ctrl_q <= `CTRL_RESET;
			half_q <= 10'(`HALF_RESET);
			recover_q <= `RECOVER_RESET;
		end else if (wr_en) begin
			if (i_PADDR == `REG_CTRL) begin
				ctrl_q <= {26'h0, i_PWDATA[5:0]};
			end
			if (i_PADDR == `REG_DIV) begin
				half_q <= clamp_half(i_PWDATA);
			end
			if (i_PADDR == `REG_RECOVER) begin
				recover_q <= i_PWDATA[15:0];
			end
		end
	end

	// Read mux; unmapped reads give zero with an error
	always_comb begin
		o_PRDATA = 32'h00000000;
		unique case (i_PADDR)
			`REG_CTRL: o_PRDATA = ctrl_q;
			`REG_DIV: o_PRDATA = {22'h0, half_q};
			`REG_DATA: o_PRDATA = {fresh_q, 7'h00, word_b_q, word_a_q};
			`REG_STATUS: o_PRDATA = {count_q, 15'h0, discard_q != 16'h0000};
			`REG_RECOVER: o_PRDATA = {16'h0000, recover_q};
			default: o_PRDATA = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sampling clock generator
	////////////////////////////////////////////////////////////////////////////

	// Equal half periods give an exact fifty percent duty; the clock free-runs
	// whenever run is set, so the converter's held charge never decays
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			div_cnt_q <= 10'h000;
			sclk_q <= 1'b0;
		end else if (ctrl_q[`CTRL_RUN]) begin
			if (div_cnt_q >= half_q - 10'h001) begin
				div_cnt_q <= 10'h000;
				sclk_q <= ~sclk_q;
			end else begin
				div_cnt_q <= div_cnt_q + 10'h001;
			end
		end
	end

	// Capture on the falling edge: the most margin after data transitions
	assign fall_pulse = ctrl_q[`CTRL_RUN] && sclk_q && div_cnt_q >= half_q - 10'h001;

	assign link.sample_clk = sclk_q;
	assign link.chan_a_out_enable_n = ctrl_q[`CTRL_OEA_N];
	assign link.chan_b_out_enable_n = ctrl_q[`CTRL_OEB_N];
	assign link.power_down_in = ctrl_q[`CTRL_PDOWN];
	assign link.format_select = ctrl_q[`CTRL_FORMAT];
	assign link.reference_select = ctrl_q[`CTRL_REFEXT];

	////////////////////////////////////////////////////////////////////////////
	// Capture path
	////////////////////////////////////////////////////////////////////////////

	// Data pins come from another chip: two flops before use
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			bus_meta_q <= 24'h000000;
			bus_sync_q <= 24'h000000;
		end else begin
			bus_meta_q <= {link.chan_b_bus, link.chan_a_bus};
			bus_sync_q <= bus_meta_q;
		end
	end

	// Detect control events that spoil words already in the pipeline
	assign pd_fall = wr_en && i_PADDR == `REG_CTRL && ctrl_q[`CTRL_PDOWN] && !i_PWDATA[`CTRL_PDOWN];
	assign fmt_chg = wr_en && i_PADDR == `REG_CTRL && ctrl_q[`CTRL_FORMAT] != i_PWDATA[`CTRL_FORMAT];
	assign run_rise = wr_en && i_PADDR == `REG_CTRL && !ctrl_q[`CTRL_RUN] && i_PWDATA[`CTRL_RUN];

	// Discard counter in sampling periods; power-down release always reloads it, format change and start only raise it
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			discard_q <= 16'(`PIPE_LATENCY + 1);
		end else if (pd_fall) begin
			discard_q <= recover_q + 16'(`PIPE_LATENCY + 1);
		end else if (fmt_chg && discard_q < 16'(`FMT_DISCARD)) begin
			discard_q <= 16'(`FMT_DISCARD);
		end else if (run_rise && discard_q < 16'(`PIPE_LATENCY + 1)) begin
			discard_q <= 16'(`PIPE_LATENCY + 1);
		end else if (fall_pulse && discard_q != 16'h0000) begin
			discard_q <= discard_q - 16'h0001;
		end
	end

	// Words are kept only when not discarding and not powered down; a data
	// read clears fresh, but a capture in the same cycle wins
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			word_a_q <= 12'h000;
			word_b_q <= 12'h000;
			fresh_q <= 1'b0;
			count_q <= 16'h0000;
		end else if (fall_pulse && discard_q == 16'h0000 && !ctrl_q[`CTRL_PDOWN]) begin
			if (!ctrl_q[`CTRL_OEA_N]) begin
				word_a_q <= bus_sync_q[11:0];
			end
			if (!ctrl_q[`CTRL_OEB_N]) begin
				word_b_q <= bus_sync_q[23:12];
			end
			fresh_q <= 1'b1;
			count_q <= count_q + 16'h0001;
		end else if (rd_en && i_PADDR == `REG_DATA) begin
			fresh_q <= 1'b0;
		end
	end

endmodule : adc_capture_host

`default_nettype wire

// ### test/adc_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module adc_link_assertions (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	input wire logic i_sample_clk,
	input wire logic i_chan_a_out_enable_n,
	input wire logic i_chan_b_out_enable_n,
	input wire logic i_power_down_in,
	input wire logic i_format_select,
	input wire adc_ctrl_pkg::sample_type i_chan_a_data,
	input wire logic i_chan_a_data_oe_n,
	input wire adc_ctrl_pkg::sample_type i_chan_b_data,
	input wire logic i_chan_b_data_oe_n
);
	import adc_ctrl_pkg::*;

	// One clock domain; checks rest while reset is low
	default clocking dc @(posedge I_MCLK);
	endclocking
	default disable iff (!I_ARST_N);

	////////////////////////////////////////
	// Enable pins reach the lane drivers within the synchroniser delay
	property p_oea_off;
		$rose(i_chan_a_out_enable_n) |-> ##[1:4] i_chan_a_data_oe_n;
	endproperty
	a_oea_off: assert property (p_oea_off) else $error("lane A not released");
	property p_oeb_off;
		$rose(i_chan_b_out_enable_n) |-> ##[1:4] i_chan_b_data_oe_n;
	endproperty
	a_oeb_off: assert property (p_oeb_off) else $error("lane B not released");
	property p_oea_on;
		$fell(i_chan_a_out_enable_n) ##1 (!i_chan_a_out_enable_n) [*4] |-> !i_chan_a_data_oe_n;
	endproperty
	a_oea_on: assert property (p_oea_on) else $error("lane A not driven");
	property p_oeb_on;
		$fell(i_chan_b_out_enable_n) ##1 (!i_chan_b_out_enable_n) [*4] |-> !i_chan_b_data_oe_n;
	endproperty
	a_oeb_on: assert property (p_oeb_on) else $error("lane B not driven");

	// Power-down flushes both lanes; zero stands for undefined
	property p_pd_zero;
		i_power_down_in [*6] |-> i_chan_a_data == 12'h000 && i_chan_b_data == 12'h000;
	endproperty
	a_pd_zero: assert property (p_pd_zero) else $error("words kept in power-down");

	// Outside power-down, words move only just after a sampling rise, never mid-period
	property p_word_hold;
		($changed(i_chan_a_data) || $changed(i_chan_b_data)) && !i_power_down_in
			&& i_format_select == $past(i_format_select, 6) |-> $past(i_sample_clk, 2);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("word moved off the rise");

	// Each half of the sampling clock lasts at least four cycles
	property p_sclk_high;
		$rose(i_sample_clk) |-> i_sample_clk [*4];
	endproperty
	a_sclk_high: assert property (p_sclk_high) else $error("high half too short");
	property p_sclk_low;
		$fell(i_sample_clk) |-> (!i_sample_clk) [*4];
	endproperty
	a_sclk_low: assert property (p_sclk_low) else $error("low half too short");

	// Main scenarios reached
	c_pd: cover property (i_power_down_in [*6]);
	c_float: cover property ($rose(i_chan_a_data_oe_n));
	c_twos: cover property ($changed(i_chan_a_data) && i_format_select);

endmodule : adc_link_assertions

`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module tb_top;
	import adc_ctrl_pkg::*;

	typedef struct {
		logic [31:0] val;
		logic [31:0] msk;
		logic err;
	} note_type;

	localparam int LIMIT = 12000;

	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	sample_type samp_a = 12'h000;
	sample_type samp_b = 12'h000;
	logic taken, low_power, ext_ref, a_driven, b_driven;
	note_type notes[$];
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int taken_cnt = 0;
	int seed_word;

	adc_link_if adc_link_if_i ();

	adc_dual_device adc_dual_device_i (
		.I_MCLK(mclk),
		.I_ARST_N(arst_n),
		.link(adc_link_if_i.device),
		.i_CHAN_A_SAMPLE(samp_a),
		.i_CHAN_B_SAMPLE(samp_b),
		.o_SAMPLE_TAKEN(taken),
		.o_LOW_POWER(low_power),
		.o_EXT_REF_SELECTED(ext_ref),
		.o_CHAN_A_DRIVEN(a_driven),
		.o_CHAN_B_DRIVEN(b_driven)
	);

	adc_capture_host adc_capture_host_i (
		.I_MCLK(mclk),
		.I_ARST_N(arst_n),
		.link(adc_link_if_i.host),
		.i_PSEL(psel),
		.i_PENABLE(penable),
		.i_PWRITE(pwrite),
		.i_PADDR(paddr),
		.i_PWDATA(pwdata),
		.o_PRDATA(prdata),
		.o_PREADY(pready),
		.o_PSLVERR(pslverr)
	);

	adc_link_assertions adc_link_assertions_i (
		.I_MCLK(mclk),
		.I_ARST_N(arst_n),
		.i_sample_clk(adc_link_if_i.sample_clk),
		.i_chan_a_out_enable_n(adc_link_if_i.chan_a_out_enable_n),
		.i_chan_b_out_enable_n(adc_link_if_i.chan_b_out_enable_n),
		.i_power_down_in(adc_link_if_i.power_down_in),
		.i_format_select(adc_link_if_i.format_select),
		.i_chan_a_data(adc_link_if_i.chan_a_data),
		.i_chan_a_data_oe_n(adc_link_if_i.chan_a_data_oe_n),
		.i_chan_b_data(adc_link_if_i.chan_b_data),
		.i_chan_b_data_oe_n(adc_link_if_i.chan_b_data_oe_n)
	);

	////////////////////////////////////////
	// 200 MHz clock
	always #2.5 mclk = ~mclk;

	task automatic give_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task automatic report(input string msg);
		fails++;
		$display("MISMATCH t=%0t %s", $time, msg);
	endtask : report

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask : end_test

	// Cut a hang short
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			report("timeout");
			give_verdict();
		end
	end

	// Count samples taken, to see conversion stop and resume
	always @(posedge mclk) begin
		if (taken === 1'b1) begin
			taken_cnt <= taken_cnt + 1;
		end
	end

	////////////////////////////////////////
	// One APB transfer; the request stands until pready is seen high, and only
	// the bench timeout cuts a wait short
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr_reg

	// The driver notes what a read must return before issuing it
	task automatic rd_reg(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m, input logic e);
		notes.push_back('{v, m, e});
		apb(1'b0, a, 32'h0);
	endtask : rd_reg

	task automatic compare_word();
		note_type e;
		comparisons++;
		if (notes.size() == 0) begin
			report("read without note");
		end else begin
			e = notes.pop_front();
			if ((prdata & e.msk) !== (e.val & e.msk) || pslverr !== e.err) begin
				report($sformatf("read %h err %b, want %h err %b", prdata, pslverr, e.val, e.err));
			end
		end
	endtask : compare_word

	// Watcher takes the oldest note at each completed read
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			compare_word();
		end
	end

	task automatic compare_flag(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			report($sformatf("flag %b, want %b", got, exp));
		end
	endtask : compare_flag

	task automatic compare_bus(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			report($sformatf("bus %h, want %h", got, exp));
		end
	endtask : compare_bus

	// Offset binary to the selected format
	function automatic sample_type fmtw(input sample_type s, input logic f);
		fmtw = {s[11] ^ f, s[10:0]};
	endfunction : fmtw

	task automatic settle();
		repeat (300) @(posedge mclk);
	endtask : settle

	task automatic check_lanes(input sample_type ea, input sample_type eb, input logic a_off);
		rd_reg(`REG_DATA, {8'h00, eb, ea}, 32'h00FFFFFF, 1'b0);
		// A released lane carries no word, so its enable is what is judged
		if (a_off) begin
			compare_flag(adc_link_if_i.chan_a_data_oe_n, 1'b1);
		end else begin
			compare_bus(adc_link_if_i.chan_a_bus, ea);
		end
		compare_bus(adc_link_if_i.chan_b_bus, eb);
	endtask : check_lanes

	////////////////////////////////////////
	// Main sequence
	initial begin
		sample_type a, b, ha;
		logic f;
		int t0;
		seed_word = $urandom(32'hB7E7);
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		rd_reg(`REG_CTRL, 32'h30, 32'h3F, 1'b0);
		rd_reg(`REG_DIV, 32'h0A, 32'h3FF, 1'b0);
		rd_reg(`REG_RECOVER, 32'h400, 32'hFFFF, 1'b0);
		rd_reg(12'h020, 32'h0, 32'hFFFFFFFF, 1'b1);
		compare_flag(adc_link_if_i.chan_a_data_oe_n, 1'b1);
		wr_reg(`REG_DIV, 32'h02);
		rd_reg(`REG_DIV, 32'h04, 32'h3FF, 1'b0);
		wr_reg(`REG_RECOVER, 32'h02);
		end_test("reset");
		// Both formats over mid-scale, the ends of the range and random words
		for (int j = 0; j < 8; j++) begin
			f = j[0];
			a = (j < 2) ? 12'h800 : (j < 4) ? 12'hFFF : sample_type'($urandom);
			b = (j < 4) ? 12'h000 : sample_type'($urandom);
			samp_a <= a;
			samp_b <= b;
			wr_reg(`REG_CTRL, {29'h0, f, 2'b01});
			// Start-up or a format flip must leave the host discarding
			rd_reg(`REG_STATUS, 32'h1, 32'h1, 1'b0);
			settle();
			check_lanes(fmtw(a, f), fmtw(b, f), 1'b0);
			compare_flag(a_driven, 1'b1);
		end
		end_test("format");
		ha = fmtw(a, 1'b1);
		a = sample_type'($urandom);
		b = sample_type'($urandom);
		samp_a <= a;
		samp_b <= b;
		wr_reg(`REG_CTRL, 32'h15);
		settle();
		check_lanes(ha, fmtw(b, 1'b1), 1'b1);
		compare_flag(a_driven, 1'b0);
		compare_flag(b_driven, 1'b1);
		wr_reg(`REG_CTRL, 32'h05);
		settle();
		check_lanes(fmtw(a, 1'b1), fmtw(b, 1'b1), 1'b0);
		end_test("enable");
		// Lane B is hidden meanwhile; it must come back full without a refill
		wr_reg(`REG_CTRL, 32'h2D);
		repeat (10) @(posedge mclk);
		compare_flag(ext_ref, 1'b1);
		compare_flag(b_driven, 1'b0);
		wr_reg(`REG_CTRL, 32'h05);
		repeat (10) @(posedge mclk);
		compare_flag(ext_ref, 1'b0);
		compare_flag(b_driven, 1'b1);
		end_test("reference");
		wr_reg(`REG_CTRL, 32'h07);
		repeat (20) @(posedge mclk);
		t0 = taken_cnt;
		compare_flag(low_power, 1'b1);
		compare_flag(a_driven, 1'b0);
		compare_bus(adc_link_if_i.chan_a_bus, 12'h000);
		a = sample_type'($urandom);
		b = sample_type'($urandom);
		samp_a <= a;
		samp_b <= b;
		settle();
		compare_flag(taken_cnt == t0, 1'b1);
		wr_reg(`REG_CTRL, 32'h05);
		repeat (20) @(posedge mclk);
		compare_flag(low_power, 1'b0);
		rd_reg(`REG_STATUS, 32'h1, 32'h1, 1'b0);
		settle();
		check_lanes(fmtw(a, 1'b1), fmtw(b, 1'b1), 1'b0);
		compare_flag(taken_cnt > t0, 1'b1);
		end_test("power down");
		give_verdict();
	end

endmodule : tb_top

`default_nettype wire
